//--- bench/fio_board.sv
// Purpose: Board circuitry on the five I/O wires
// Assumes: Device enable wins; the bench drives only where it is input
// Notes:   Undriven wires toggle each clock so no stale level survives
`timescale 1ns/1ps
module fio_board (
  input wire logic pclk,
  input wire logic [4:0] dev_o,
  input wire logic [4:0] dev_oe,
  input wire logic [4:0] ext_v,
  input wire logic [4:0] ext_en,
  output logic [4:0] wire_lvl
);
  logic [4:0] flt_q = 5'h0a;
  always @(posedge pclk) flt_q <= ~flt_q;
  // Floating wire has no pull, so it shows a changing pattern
  assign wire_lvl = (dev_oe & dev_o) | (~dev_oe & ext_en & ext_v) |
    (~dev_oe & ~ext_en & flt_q);
endmodule

//--- bench/five_bit_io_and_input_port_tb_top.sv
// Purpose: Self-checking bench of the port block
// Assumes: APB master waits on pready; board model sits on the I/O wires
// Notes:   Random values come from a shift register with a fixed start
`timescale 1ns/1ps
`include "fio_cfg.svh"
module five_bit_io_and_input_port_tb_top
  import fio_pkg::*;
;
  localparam logic [17:0] A_LAT = {`FIO_IDX_LATCH, 2'b00};
  localparam logic [17:0] A_LVL = {`FIO_IDX_LEVELS, 2'b00};
  localparam logic [17:0] A_DIR = {`FIO_IDX_DIR, 2'b00};
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [17:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd, seed = 32'h1426;
  logic [3:0] pstrb = 4'h1, ch = 4'hf, c;
  logic pready, pslverr, er;
  fio_mode_t op_mode = fio_active;
  fio_mode_t mt[6] = '{fio_sleep, fio_subsleep, fio_watch, fio_standby,
    fio_subactive, fio_active};
  logic [4:0] pin_o, pin_oe, lvl, ext_v = 5'h15, ext_en = 5'h1f;
  logic [4:0] d, l, e, po, poe;
  logic [7:0] inp = 8'ha5, p;
  int errors = 0, n_checks = 0;
  always #50 pclk = ~pclk;
  fio_ports u_fio_ports (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .op_mode(op_mode), .analog_channel_select(ch), .io_port_pin_i(lvl),
    .io_port_pin_o(pin_o), .io_port_pin_oe(pin_oe), .input_port_pin(inp));
  fio_board u_fio_board (.pclk(pclk), .dev_o(pin_o), .dev_oe(pin_oe),
    .ext_v(ext_v), .ext_en(ext_en), .wire_lvl(lvl));
  function automatic logic [31:0] nxt(logic [31:0] s);
    return {s[30:0], 1'b0} ^ (s[31] ? 32'h04c11db7 : 32'h0);
  endfunction
  function automatic logic [31:0] exp_lat(logic [4:0] d, l, e);
    return {24'h0, `FIO_RSVD_ONES, `FIO_RSVD_ZERO, (d & l) | (~d & e)};
  endfunction
  function automatic logic [31:0] exp_lvl(logic [7:0] p, logic [3:0] c);
    if (c <= `FIO_CH_LAST) p[c[2:0]] = 1'b0;
    return {24'h0, p};
  endfunction
  task automatic end_of_test;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic apb(input logic wr, input logic [17:0] a,
      input logic [31:0] wd);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 20);
    if (i >= 20) begin
      errors++;
      end_of_test();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, A_LAT, 0);
    chk("latch reset", rd, exp_lat(5'h0, 5'h0, 5'h15));
    apb(0, A_DIR, 0);
    chk("dir read", rd, {24'h0, `FIO_DIR_READ});
    chk("oe reset", 32'(pin_oe), 32'h0);
    ext_en <= 5'h0;
    apb(1, A_DIR, 32'h1f);
    apb(0, A_LAT, 0);
    chk("latch reset out", rd, {24'h0, `FIO_LATCH_RST});
    chk("drive reset", 32'(pin_o), 32'h0);
    for (int k = 0; k < 24; k++) begin
      seed = nxt(seed);
      {c, p, e, l, d} = seed[26:0];
      ch <= c;
      inp <= p;
      apb(1, A_LAT, 32'hffffffe0 | 32'(l));
      apb(1, A_DIR, 32'(d));
      ext_en <= ~d;
      ext_v <= e;
      apb(1, A_LVL, 32'(~p));
      chk("level write err", 32'(er), 32'h0);
      apb(0, A_LAT, 0);
      chk("latch read", rd, exp_lat(d, l, e));
      chk("oe", 32'(pin_oe), 32'(d));
      chk("drive", 32'(pin_o & d), 32'(l & d));
      apb(0, A_LVL, 0);
      chk("levels", rd, exp_lvl(p, c));
      apb(0, A_DIR, 0);
      chk("dir read", rd, {24'h0, `FIO_DIR_READ});
    end
    pstrb <= 4'h0;
    apb(1, A_LAT, 32'(~l));
    pstrb <= 4'h1;
    apb(0, A_LAT, 0);
    chk("strobeless write", rd, exp_lat(d, l, e));
    apb(0, 18'h3ff78, 0);
    chk("unmapped err", 32'(er), 32'h1);
    chk("unmapped data", rd, 32'h0);
    po = l;
    poe = d;
    foreach (mt[i]) begin
      seed = nxt(seed);
      l = seed[4:0];
      op_mode <= mt[i];
      repeat (2) @(posedge pclk);
      apb(1, A_LAT, 32'(l));
      repeat (2) @(posedge pclk);
      if (mt[i] inside {fio_active, fio_subactive}) begin
        po = l;
        poe = d;
      end else if (mt[i] == fio_standby) poe = 5'h0;
      chk("mode oe", 32'(pin_oe), 32'(poe));
      chk("mode drive", 32'(pin_o), 32'(po));
    end
    presetn <= 1'b0;
    ext_en <= 5'h1f;
    repeat (2) @(posedge pclk);
    chk("oe in reset", 32'(pin_oe), 32'h0);
    presetn <= 1'b1;
    apb(0, A_LAT, 0);
    chk("latch rereset", rd, exp_lat(5'h0, 5'h0, ext_v));
    apb(1, A_DIR, 32'h1f);
    apb(0, A_LAT, 0);
    chk("latch cleared", rd, {24'h0, `FIO_LATCH_RST});
    end_of_test();
  end
endmodule

//--- hdl/fio_cfg.svh
// Purpose: Offsets, field positions and reset values of the port block
// Assumes: Included by bare name from the design files
// Notes:   Register indices are printed offsets; byte address is index * 4
`ifndef FIO_CFG_SVH
`define FIO_CFG_SVH
`define FIO_IDX_LATCH 16'hffdc
`define FIO_IDX_LEVELS 16'hffdd
`define FIO_IDX_DIR 16'hffec
`define FIO_LATCH_RST 8'hc0
`define FIO_DIR_RST 8'hc0
`define FIO_DIR_READ 8'hff
`define FIO_RSVD_ONES 2'b11
`define FIO_RSVD_ZERO 1'b0
`define FIO_IO_MSB 4
`define FIO_LVL_MSB 7
`define FIO_CH_LAST 4'h7
`endif

//--- hdl/fio_pin_hold.sv
// Purpose: Drive of the five I/O pins across power modes
// Assumes: Mode input is synchronous to pclk
// Notes:   Pin drive lags latch and direction by one clock
`timescale 1ns/1ps
module fio_pin_hold
  import fio_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire fio_mode_t op_mode,
  input wire logic [4:0] latch,
  input wire logic [4:0] dir,
  output logic [4:0] pin_o,
  output logic [4:0] pin_oe
);

  fio_pin_t q;
  fio_pin_t d;

  always_comb begin
    d = q;
    case (op_mode)
      fio_active, fio_subactive: begin
        d.out = latch; // RULE_07
        d.oe = dir; // RULE_07
      end
      fio_sleep, fio_subsleep, fio_watch: begin
        d = q; // RULE_10
      end
      fio_standby: begin
        d.oe = 5'h00; // RULE_10
      end
      default: begin
        d.oe = 5'h00;
      end
    endcase
  end

  // Reset clears the enables, so the pins float while reset is held
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0; // RULE_10
    end else begin
      q <= d;
    end
  end

  assign pin_o = q.out;
  assign pin_oe = q.oe;

  sequence s_run;
    op_mode == fio_active || op_mode == fio_subactive;
  endsequence

  sequence s_hold;
    op_mode == fio_sleep || op_mode == fio_subsleep || op_mode == fio_watch;
  endsequence

  property p_drive_follows;
    @(posedge pclk) disable iff (!presetn)
      s_run |=> pin_oe == $past(dir) && pin_o == $past(latch);
  endproperty
  a_drive_follows: assert property (p_drive_follows) // RULE_07
    else $error("Pin drive does not follow latch and direction");

  property p_standby_float;
    @(posedge pclk) disable iff (!presetn)
      op_mode == fio_standby |=> pin_oe == 5'h00;
  endproperty
  a_standby_float: assert property (p_standby_float) // RULE_10
    else $error("Pin driven in standby");

  property p_hold_state;
    @(posedge pclk) disable iff (!presetn)
      s_hold ##1 s_hold |-> $stable(pin_o) && $stable(pin_oe);
  endproperty
  a_hold_state: assert property (p_hold_state) // RULE_10
    else $error("Pin state changed in a holding mode");

endmodule

//--- hdl/fio_pkg.sv
// Purpose: Types shared by the port block
// Assumes: Constants live in fio_cfg.svh
// Notes:   Power modes come from the chip's mode controller
package fio_pkg;

  typedef enum logic [2:0] {
    fio_active,
    fio_subactive,
    fio_sleep,
    fio_subsleep,
    fio_watch,
    fio_standby
  } fio_mode_t;

  typedef struct packed {
    logic [7:0] latch;
    logic [7:0] dir;
    logic [31:0] rdata;
    logic err;
  } fio_regs_t;

  typedef struct packed {
    logic [4:0] out;
    logic [4:0] oe;
  } fio_pin_t;

endpackage

//--- hdl/fio_ports.sv
// Purpose: Five-bit I/O port and eight-bit input port behind an APB slave
// Assumes: Pin inputs are synchronous to pclk; pclk runs at 10 MHz
// Notes:   Zero wait state slave; unmapped addresses answer with pslverr
//
// How it works
// RULE_01: I/O port has five pins, bits 4..0.
// RULE_02: Latch bits 7 and 6 read one.
// RULE_03: Latch bit 5 reads zero.
// RULE_04: Output pin reads back its latched value.
// RULE_05: Input pin reads back its pin level.
// RULE_06: Latch resets to c0.
// RULE_07: Direction one drives pin from latch.
// RULE_08: Direction resets to c0, all inputs.
// RULE_09: Direction register reads as all ones.
// RULE_10: Float in reset, standby; hold when sleeping.
// RULE_11: Input port: eight pins, read only.
// RULE_12: Input port read gives live pin levels.
// RULE_13: Channel-selected input pin reads zero.
// RULE_14: Input port pins never drive.
// RULE_15: Software sets unused pins to output early.
// RULE_16: Channel codes 0..7 pick pin n.
`timescale 1ns/1ps
`include "fio_cfg.svh"
module fio_ports
  import fio_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [17:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire fio_mode_t op_mode,
  input wire logic [3:0] analog_channel_select,
  input wire logic [4:0] io_port_pin_i,
  output logic [4:0] io_port_pin_o,
  output logic [4:0] io_port_pin_oe,
  input wire logic [7:0] input_port_pin // RULE_14
);

  localparam logic [17:0] A_LATCH = {`FIO_IDX_LATCH, 2'b00};
  localparam logic [17:0] A_LEVELS = {`FIO_IDX_LEVELS, 2'b00};
  localparam logic [17:0] A_DIR = {`FIO_IDX_DIR, 2'b00};

  fio_regs_t q;
  fio_regs_t d;

  logic setup;
  logic wr_acc;
  logic [7:0] chan_mask;
  logic [7:0] levels;
  logic [4:0] io_rd;
  logic [7:0] latch_rd;

  // Codes above seven select no port pin, so nothing is masked then
  function automatic logic [7:0] fio_chan_mask(input logic [3:0] sel);
    logic [7:0] m;
    m = 8'h00;
    if (sel <= `FIO_CH_LAST) begin // RULE_16
      m = 8'h01 << sel[2:0]; // RULE_16
    end
    return m;
  endfunction

  function automatic logic fio_mapped(input logic [17:0] a);
    return a == A_LATCH || a == A_LEVELS || a == A_DIR;
  endfunction

  assign chan_mask = fio_chan_mask(analog_channel_select);

  genvar g;
  generate
    // Input port has no output path at all; it only samples the pin
    for (g = 0; g <= `FIO_LVL_MSB; g++) begin : g_lvl
      assign levels[g] = input_port_pin[g] & ~chan_mask[g]; // RULE_13
    end
    for (g = 0; g <= `FIO_IO_MSB; g++) begin : g_io
      // Output pins return the latch, not the wire, even if loaded
      assign io_rd[g] = q.dir[g] ? q.latch[g] // RULE_04
                                 : io_port_pin_i[g]; // RULE_05
    end
  endgenerate

  assign latch_rd = {`FIO_RSVD_ONES, `FIO_RSVD_ZERO, io_rd}; // RULE_02

  function automatic logic [31:0] fio_read(input logic [17:0] a);
    logic [31:0] w;
    w = 32'h0000_0000;
    case (a)
      A_LATCH: begin
        w[7:0] = latch_rd; // RULE_03
      end
      A_LEVELS: begin
        w[7:0] = levels; // RULE_12
      end
      A_DIR: begin
        w[7:0] = `FIO_DIR_READ; // RULE_09
      end
      default: begin
        w = 32'h0000_0000;
      end
    endcase
    return w;
  endfunction

  assign setup = psel && !penable;
  assign wr_acc = psel && penable && pwrite && pstrb[0];

  always_comb begin
    d = q;
    if (setup) begin
      d.rdata = pwrite ? 32'h0000_0000 : fio_read(paddr);
      d.err = !fio_mapped(paddr);
    end
    if (wr_acc && paddr == A_LATCH) begin
      // Only the five pin bits store; bits 7..5 keep their constants
      d.latch[`FIO_IO_MSB:0] = pwdata[`FIO_IO_MSB:0]; // RULE_01
    end
    if (wr_acc && paddr == A_DIR) begin
      d.dir[`FIO_IO_MSB:0] = pwdata[`FIO_IO_MSB:0]; // RULE_07
    end
    // Writes to the level register are ignored; it has no latch
    if (wr_acc && paddr == A_LEVELS) begin
      d.latch = d.latch; // RULE_11
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q.latch <= `FIO_LATCH_RST; // RULE_06
      q.dir <= `FIO_DIR_RST; // RULE_08
      q.rdata <= 32'h0000_0000;
      q.err <= 1'b0;
    end else begin
      q <= d;
    end
  end

  // No wait states: every access phase completes in its first cycle
  assign pready = 1'b1;
  assign pslverr = psel && penable && q.err;
  assign prdata = q.rdata;

  fio_pin_hold u_pins (
    .pclk(pclk),
    .presetn(presetn),
    .op_mode(op_mode),
    .latch(q.latch[`FIO_IO_MSB:0]),
    .dir(q.dir[`FIO_IO_MSB:0]),
    .pin_o(io_port_pin_o),
    .pin_oe(io_port_pin_oe)
  );

  sequence s_rd_setup(logic [17:0] a);
    psel && !penable && !pwrite && paddr == a;
  endsequence

  sequence s_access;
    psel && penable;
  endsequence

  property p_reserved_bits;
    @(posedge pclk) disable iff (!presetn)
      s_rd_setup(A_LATCH) ##1 s_access |-> prdata[7:5] == 3'b110;
  endproperty
  a_reserved_bits: assert property (p_reserved_bits) // RULE_02
    else $error("Latch reserved bits read wrong");

  property p_out_reads_latch;
    @(posedge pclk) disable iff (!presetn)
      s_rd_setup(A_LATCH) |=>
        (prdata[4:0] & $past(q.dir[4:0])) ==
        ($past(q.latch[4:0]) & $past(q.dir[4:0]));
  endproperty
  a_out_reads_latch: assert property (p_out_reads_latch) // RULE_04
    else $error("Output pin did not read its latch");

  property p_in_reads_pin;
    @(posedge pclk) disable iff (!presetn)
      s_rd_setup(A_LATCH) |=>
        (prdata[4:0] & ~$past(q.dir[4:0])) ==
        ($past(io_port_pin_i) & ~$past(q.dir[4:0]));
  endproperty
  a_in_reads_pin: assert property (p_in_reads_pin) // RULE_05
    else $error("Input pin did not read its level");

  property p_dir_reads_ones;
    @(posedge pclk) disable iff (!presetn)
      s_rd_setup(A_DIR) ##1 s_access |-> prdata == 32'h0000_00ff;
  endproperty
  a_dir_reads_ones: assert property (p_dir_reads_ones) // RULE_09
    else $error("Direction register did not read all ones");

  property p_levels_live;
    @(posedge pclk) disable iff (!presetn)
      s_rd_setup(A_LEVELS) |=>
        prdata[7:0] == ($past(input_port_pin) & ~$past(chan_mask));
  endproperty
  a_levels_live: assert property (p_levels_live) // RULE_12
    else $error("Input port read differs from pin levels");

  property p_chan_zero;
    @(posedge pclk) disable iff (!presetn)
      s_rd_setup(A_LEVELS) ##0 analog_channel_select <= 4'h7 |=>
        prdata[$past(analog_channel_select[2:0])] == 1'b0;
  endproperty
  a_chan_zero: assert property (p_chan_zero) // RULE_13
    else $error("Selected analog pin did not read zero");

  property p_reset_values;
    @(posedge pclk) disable iff (!presetn)
      !$past(presetn) |-> q.latch == 8'hc0 && q.dir == 8'hc0
        && io_port_pin_oe == 5'h00;
  endproperty
  a_reset_values: assert property (p_reset_values) // RULE_06
    else $error("Latch or direction not at reset value");

  property p_latch_write;
    @(posedge pclk) disable iff (!presetn)
      wr_acc && paddr == A_LATCH |=>
        q.latch == {3'b110, $past(pwdata[4:0])};
  endproperty
  a_latch_write: assert property (p_latch_write) // RULE_01
    else $error("Latch write not stored");

  property p_dir_write;
    @(posedge pclk) disable iff (!presetn)
      wr_acc && paddr == A_DIR |=>
        q.dir == {3'b110, $past(pwdata[4:0])} ##1
        (op_mode != fio_active || io_port_pin_oe == q.dir[4:0]);
  endproperty
  a_dir_write: assert property (p_dir_write) // RULE_08
    else $error("Direction write not stored or not applied");

  property p_unmapped_err;
    @(posedge pclk) disable iff (!presetn)
      setup && !fio_mapped(paddr) ##1 s_access |-> pslverr;
  endproperty
  a_unmapped_err: assert property (p_unmapped_err) // RULE_11
    else $error("Unmapped access gave no error");

  property p_levels_no_err;
    @(posedge pclk) disable iff (!presetn)
      setup && paddr == A_LEVELS ##1 s_access |-> !pslverr;
  endproperty
  a_levels_no_err: assert property (p_levels_no_err) // RULE_11
    else $error("Level register access flagged an error");

  property p_levels_width;
    @(posedge pclk) disable iff (!presetn)
      s_rd_setup(A_LEVELS) |=> prdata[31:8] == 24'h00_0000;
  endproperty
  a_levels_width: assert property (p_levels_width) // RULE_11
    else $error("Input port read set bits above its eight pins");

  // The level register has no storage, so its writes must leave no trace
  property p_levels_wr_ignored;
    @(posedge pclk) disable iff (!presetn)
      wr_acc && paddr == A_LEVELS |=>
        q.latch == $past(q.latch) && q.dir == $past(q.dir);
  endproperty
  a_levels_wr_ignored: assert property (p_levels_wr_ignored) // RULE_11
    else $error("Write to the input port changed a register");

  property p_strobe_gate;
    @(posedge pclk) disable iff (!presetn)
      psel && penable && pwrite && !pstrb[0] |=>
        q.latch == $past(q.latch) && q.dir == $past(q.dir);
  endproperty
  a_strobe_gate: assert property (p_strobe_gate) // RULE_01
    else $error("Write without byte strobe changed a register");

  property p_dir_keeps_latch;
    @(posedge pclk) disable iff (!presetn)
      wr_acc && paddr == A_DIR |=> q.latch == $past(q.latch);
  endproperty
  a_dir_keeps_latch: assert property (p_dir_keeps_latch) // RULE_07
    else $error("Direction write disturbed the latch");

  // Looked at one cycle into reset, once the asynchronous clear has settled
  property p_reset_float;
    @(posedge pclk) !presetn ##1 !presetn |-> io_port_pin_oe == 5'h00;
  endproperty
  a_reset_float: assert property (p_reset_float) // RULE_10
    else $error("Pin driven during reset");

  property p_chan_none;
    @(posedge pclk) disable iff (!presetn)
      s_rd_setup(A_LEVELS) ##0 analog_channel_select > 4'h7 |=>
        prdata[7:0] == $past(input_port_pin);
  endproperty
  a_chan_none: assert property (p_chan_none) // RULE_16
    else $error("Channel code above seven masked a pin");

  property p_chan_others;
    @(posedge pclk) disable iff (!presetn)
      s_rd_setup(A_LEVELS) ##0 analog_channel_select <= 4'h7 |=>
        (prdata[7:0] | (8'h01 << $past(analog_channel_select[2:0]))) ==
        ($past(input_port_pin) |
          (8'h01 << $past(analog_channel_select[2:0])));
  endproperty
  a_chan_others: assert property (p_chan_others) // RULE_12
    else $error("Unselected input pin did not read its level");

endmodule
